/* File: sbl_buf2.v */
// Two-entry valid/ready buffer for received bytes
`timescale 1ns/1ps
module sbl_buf2 (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // Fill side
    input  wire       in_valid,
    output wire       in_ready,
    input  wire [7:0] in_data,
    // Drain side
    output wire       out_valid,
    input  wire       out_ready,
    output wire [7:0] out_data
);
    reg [7:0] mem_q [0:1];
    reg       wp_q;
    reg       rp_q;
    reg [1:0] cnt_q;
    wire      push;
    wire      pop;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q        <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            if (push & ~pop)
                cnt_q <= cnt_q + 2'h1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule // sbl_buf2

/* File: sbl_consts.vh */
// Constants of the serial boot loader entry logic
`ifndef SBL_CONSTS_VH
`define SBL_CONSTS_VH
// ----------------------------------------
// Forced configuration values
// ----------------------------------------
`define SBL_SYSTEM_CONFIGURATION_VAL   16'h0E00
`define SBL_CP_VAL       16'hFA00
`define SBL_SP_VAL       16'hFA40
`define SBL_STACK_UNDERFLOW_LIMIT_VAL    16'hFA40
`define SBL_STACK_OVERFLOW_LIMIT_VAL    16'hFA0C
`define SBL_SCON_VAL     16'h8011
// ----------------------------------------
// Startup load area and baud arithmetic
// ----------------------------------------
`define SBL_LOAD_BASE    24'h00FA40
`define SBL_LOAD_LAST    24'h00FA5F
`define SBL_LOAD_COUNT   6'h20
`define SBL_BAUD_SUB     16'h0024
`define SBL_BAUD_DIV     16'h0048
`define SBL_SAMPLES_BIT  5'h10
// ----------------------------------------
// Memory map
// ----------------------------------------
`define SBL_FLASH_SEG0   8'h00
`define SBL_FLASH_SEG1   8'h01
`define SBL_FLASH_TOP    16'h7FFF
// ----------------------------------------
// Register bus offsets
// ----------------------------------------
`define SBL_REG_STATUS   12'h000
`define SBL_REG_CTRL     12'h004
`define SBL_REG_BAUD     12'h008
`define SBL_REG_CFG0     12'h00C
`define SBL_REG_CFG1     12'h010
`define SBL_REG_CFG2     12'h014
`define SBL_REG_DATA     12'h018
`define SBL_REG_ID       12'h01C
`define SBL_ID_DEFAULT   8'h5A
`endif

/* File: sbl_host_model.sv */
// Host model: sends zero byte, reads id byte, sends startup bytes
`timescale 1ns/1ps
module sbl_host_model (
    // Clock and control
    input wire         core_clk,
    input wire         start,
    input wire [15:0]  zero_len,
    input wire [15:0]  bit_clks,
    input wire [255:0] payload,
    // Serial link
    input wire         serial_transmit_pin,
    output reg         serial_receive_pin,
    // Observed answer
    output reg [7:0]   id_byte,
    output reg         id_ok
);
    reg [9:0] frame;
    integer   i, k, n;
    initial begin
        serial_receive_pin = 1'b1;
        id_byte = 8'h00;
        id_ok = 1'b0;
    end
    always @(posedge start) begin
        // Zero byte, line back high after
        @(posedge core_clk);
        serial_receive_pin <= 1'b0;
        repeat (zero_len) @(posedge core_clk);
        serial_receive_pin <= 1'b1;
        // Wait for id frame first
        n = 0;
        while (serial_transmit_pin !== 1'b0 && n < 5000) begin
            @(posedge core_clk);
            n = n + 1;
        end
        repeat (bit_clks / 2) @(posedge core_clk);
        for (i = 0; i < 10; i = i + 1) begin
            frame[i] = serial_transmit_pin;
            repeat (bit_clks) @(posedge core_clk);
        end
        id_byte = frame[8:1];
        id_ok = frame[0] === 1'b0 && frame[9] === 1'b1;
        // Half duplex: bytes only after the id, LSB first
        for (k = 0; k < 32; k = k + 1) begin
            for (i = 0; i < 10; i = i + 1) begin
                serial_receive_pin <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : payload[k*8+i-1];
                repeat (bit_clks) @(posedge core_clk);
            end
        end
    end
endmodule // sbl_host_model

/* File: sbl_loader.v */
// Serial boot loader entry logic: mode latch, baud measure, id send, startup bytes
//
// How it works
// - Boot mode entered when boot-select pin is low as hardware reset ends.
// - Boot mode entry ignores the external bus mode strap.
// - After entry, receive line is watched for a zero byte.
// - Zero byte length gives baud factor and programs the channel; transmit pin is output from boot entry.
// - One identification byte is sent back at the derived baud rate.
// - Watchdog held disabled throughout boot mode.
// - Boot entry forces configuration, stack and serial control values.
// - Transmit port bit made output and driven high.
// - Receiver enabled after id byte for the first 32 bytes.
// - No instruction executes from internal flash in boot mode.
// - External-access pin ignored for memory config in boot mode.
// - Flash code fetches go to boot ROM; data reads see user flash.
// - Boot ROM window follows flash when mapped to segment 1.
// - Bytes stored at FA40h to FA5Fh, then jump to FA40h.
// - Reload value is measured count minus 36, divided by 72.
// - Boot mode left on software reset, or hardware reset with pin high.
`timescale 1ns/1ps
`include "sbl_consts.vh"
module sbl_loader (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // Straps and resets
    input  wire        boot_select_pin,
    input  wire        external_access_pin,
    input  wire        bus_mode_strap,
    input  wire        sw_reset,
    // Serial pins
    input  wire        serial_receive_pin,
    output reg         serial_transmit_pin,
    output wire        transmit_direction_bit,
    // Startup byte stream to RAM
    output wire        ram_wr_valid,
    input  wire        ram_wr_ready,
    output reg  [23:0] ram_wr_addr,
    output wire [7:0]  ram_wr_data,
    output reg         jump_valid,
    output wire [23:0] jump_addr,
    // Forced configuration
    output wire        boot_loader_mode,
    output wire        watchdog_disable,
    output wire        cfg_load,
    output wire [15:0] system_configuration,
    output wire [15:0] context_base_pointer,
    output wire [15:0] stack_pointer,
    output wire [15:0] stack_underflow_limit,
    output wire [15:0] stack_overflow_limit,
    output wire [15:0] serial_control,
    output reg  [15:0] baud_reload_value,
    // Fetch steering
    input  wire [23:0] fetch_addr,
    input  wire        fetch_is_code,
    input  wire        flash_in_seg1,
    output wire        fetch_to_boot_rom,
    output wire        flash_use_external,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr
);
    // Identity value is arbitrary
    parameter [7:0] ID_BYTE = `SBL_ID_DEFAULT;

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_WAIT = 7'h02;
    localparam [6:0] ST_MEAS = 7'h04;
    localparam [6:0] ST_CALC = 7'h08;
    localparam [6:0] ST_SEND = 7'h10;
    localparam [6:0] ST_RECV = 7'h20;
    localparam [6:0] ST_DONE = 7'h40;

    function in_flash;
        input [23:0] a;
        input        seg1;
        begin
            in_flash = (a[23:16] == (seg1 ? `SBL_FLASH_SEG1 : `SBL_FLASH_SEG0)) &&
                       (a[15:0] <= `SBL_FLASH_TOP);
        end
    endfunction

    reg        mode_q;
    reg        strap_q;
    reg        armed_q;
    reg [6:0]  st_q;
    reg [15:0] meas_q;
    reg        ovf_q;
    reg        rx_q;
    reg [15:0] bit_cnt_q;
    reg [3:0]  bit_idx_q;
    reg [9:0]  tx_sh_q;
    reg [7:0]  rx_sh_q;
    reg        rx_busy_q;
    reg        rx_valid_q;
    reg [5:0]  loaded_q;
    reg        run_q;
    reg [31:0] rd_word;
    wire [15:0] bit_len;
    wire        rx_fall;
    wire        rx_rise;
    wire        buf_in_ready;

    // ----------------------------------------
    // Mode latch
    // ----------------------------------------
    // Strap caught by a clocked stage at reset release, never in the reset branch
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b1;
            mode_q  <= 1'b0;
            strap_q <= 1'b0;
        end else begin
            armed_q <= 1'b0;
            if (armed_q) begin
                mode_q  <= ~boot_select_pin;
                strap_q <= bus_mode_strap;
            end else if (sw_reset)
                mode_q <= 1'b0;
        end
    end

    assign boot_loader_mode      = mode_q;
    assign watchdog_disable      = mode_q;
    assign cfg_load              = mode_q & st_q[0];
    assign system_configuration  = `SBL_SYSTEM_CONFIGURATION_VAL;
    assign context_base_pointer  = `SBL_CP_VAL;
    assign stack_pointer         = `SBL_SP_VAL;
    assign stack_underflow_limit = `SBL_STACK_UNDERFLOW_LIMIT_VAL;
    assign stack_overflow_limit  = `SBL_STACK_OVERFLOW_LIMIT_VAL;
    assign serial_control        = `SBL_SCON_VAL;
    assign transmit_direction_bit = ~mode_q;
    assign jump_addr             = `SBL_LOAD_BASE;

    // ----------------------------------------
    // Fetch steering
    // ----------------------------------------
    assign fetch_to_boot_rom  = mode_q & fetch_is_code &
                                in_flash(fetch_addr, flash_in_seg1);
    assign flash_use_external = mode_q ? 1'b0 : ~external_access_pin;

    // ----------------------------------------
    // Serial sequencer
    // ----------------------------------------
    assign rx_fall = rx_q & ~serial_receive_pin;
    assign rx_rise = ~rx_q & serial_receive_pin;
    // One bit time is 32 clocks per reload step plus 32 clocks, 32 times (reload value + 1)
    assign bit_len = {baud_reload_value[10:0], 5'h00} + 16'h0020;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q                <= ST_IDLE;
            rx_q                <= 1'b1;
            meas_q              <= 16'h0000;
            ovf_q               <= 1'b0;
            baud_reload_value   <= 16'h0000;
            bit_cnt_q           <= 16'h0000;
            bit_idx_q           <= 4'h0;
            tx_sh_q             <= 10'h3FF;
            serial_transmit_pin <= 1'b1;
            rx_sh_q             <= 8'h00;
            rx_busy_q           <= 1'b0;
            rx_valid_q          <= 1'b0;
            loaded_q            <= 6'h00;
            jump_valid          <= 1'b0;
            ram_wr_addr         <= `SBL_LOAD_BASE;
        end else begin
            rx_q       <= serial_receive_pin;
            jump_valid <= 1'b0;
            if (rx_valid_q & buf_in_ready)
                rx_valid_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (mode_q & ~armed_q)
                        st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (rx_fall) begin
                        meas_q <= 16'h0001;
                        ovf_q  <= 1'b0;
                        st_q   <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (rx_rise)
                        st_q <= ST_CALC;
                    else if (meas_q == 16'hFFFF)
                        ovf_q <= 1'b1;
                    else
                        meas_q <= meas_q + 16'h0001;
                end
                ST_CALC: begin
                    // Too short a byte or overflow: restart the hunt
                    if (ovf_q || meas_q < `SBL_BAUD_SUB + `SBL_BAUD_DIV)
                        st_q <= ST_WAIT;
                    else begin
                        baud_reload_value <= (meas_q - `SBL_BAUD_SUB) / `SBL_BAUD_DIV;
                        tx_sh_q   <= {1'b1, ID_BYTE, 1'b0};
                        bit_idx_q <= 4'h0;
                        bit_cnt_q <= 16'h0000;
                        st_q      <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    serial_transmit_pin <= tx_sh_q[0];
                    if (bit_cnt_q == bit_len - 16'h0001) begin
                        bit_cnt_q <= 16'h0000;
                        tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                        if (bit_idx_q == 4'h9) begin
                            st_q      <= ST_RECV;
                            rx_busy_q <= 1'b0;
                        end
                        bit_idx_q <= bit_idx_q + 4'h1;
                    end else
                        bit_cnt_q <= bit_cnt_q + 16'h0001;
                end
                ST_RECV: begin
                    serial_transmit_pin <= 1'b1;
                    if (!rx_busy_q) begin
                        if (rx_fall & ~rx_valid_q) begin
                            rx_busy_q <= 1'b1;
                            bit_idx_q <= 4'h0;
                            bit_cnt_q <= {1'b0, bit_len[15:1]};
                        end
                    end else if (bit_cnt_q == bit_len - 16'h0001) begin
                        bit_cnt_q <= 16'h0000;
                        bit_idx_q <= bit_idx_q + 4'h1;
                        if (bit_idx_q == 4'h9) begin
                            rx_busy_q  <= 1'b0;
                            rx_valid_q <= 1'b1;
                        end else if (bit_idx_q != 4'h0)
                            rx_sh_q <= {serial_receive_pin, rx_sh_q[7:1]};
                    end else
                        bit_cnt_q <= bit_cnt_q + 16'h0001;
                    if (loaded_q == `SBL_LOAD_COUNT) begin
                        jump_valid <= 1'b1;
                        st_q       <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    serial_transmit_pin <= 1'b1;
                end
                default: st_q <= ST_IDLE;
            endcase
            if (sw_reset) begin
                st_q <= ST_IDLE;
                serial_transmit_pin <= 1'b1;
            end
            if (ram_wr_valid & ram_wr_ready) begin
                loaded_q    <= loaded_q + 6'h01;
                ram_wr_addr <= ram_wr_addr + 24'h000001;
            end
        end
    end

    // Two-entry buffer so a stalled RAM port loses no byte until both entries and the receive register are full
    sbl_buf2 u_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (rx_valid_q),
        .in_ready  (buf_in_ready),
        .in_data   (rx_sh_q),
        .out_valid (ram_wr_valid),
        .out_ready (ram_wr_ready),
        .out_data  (ram_wr_data)
    );

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Read word caught in the setup cycle, so it stands through the access cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q  <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            if (psel & penable & pwrite & (paddr == `SBL_REG_CTRL))
                run_q <= pwdata[0];
            if (psel & ~penable)
                prdata <= rd_word;
        end
    end

    always @* begin
        case (paddr)
            `SBL_REG_STATUS: rd_word = {15'h0000, strap_q, ovf_q, st_q, loaded_q, 1'b0, mode_q};
            `SBL_REG_CTRL:   rd_word = {31'h00000000, run_q};
            `SBL_REG_BAUD:   rd_word = {16'h0000, baud_reload_value};
            `SBL_REG_CFG0:   rd_word = {`SBL_CP_VAL, `SBL_SYSTEM_CONFIGURATION_VAL};
            `SBL_REG_CFG1:   rd_word = {`SBL_STACK_OVERFLOW_LIMIT_VAL, `SBL_STACK_UNDERFLOW_LIMIT_VAL};
            `SBL_REG_CFG2:   rd_word = {`SBL_SCON_VAL, `SBL_SP_VAL};
            `SBL_REG_DATA:   rd_word = {16'h0000, meas_q};
            `SBL_REG_ID:     rd_word = {24'h000000, ID_BYTE};
            default:         rd_word = 32'h00000000;
        endcase
    end
endmodule // sbl_loader

/* File: sbl_loader_properties.sv */
// Assertion checker for the serial boot loader entry logic
`timescale 1ns/1ps
module sbl_loader_props (
    // Clock and reset
    input wire        core_clk,
    input wire        rst_n,
    // Inputs seen
    input wire        sw_reset,
    input wire        external_access_pin,
    input wire [23:0] fetch_addr,
    input wire        fetch_is_code,
    input wire        flash_in_seg1,
    input wire        ram_wr_ready,
    // Outputs watched
    input wire        boot_loader_mode,
    input wire        watchdog_disable,
    input wire        transmit_direction_bit,
    input wire        fetch_to_boot_rom,
    input wire        flash_use_external,
    input wire        ram_wr_valid,
    input wire [23:0] ram_wr_addr,
    input wire [7:0]  ram_wr_data,
    input wire        jump_valid,
    input wire [23:0] jump_addr,
    input wire        cfg_load,
    input wire [15:0] system_configuration,
    input wire [15:0] serial_control
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Flash window moves with the segment mapping
    wire in_flash = fetch_addr[23:16] == {7'h00, flash_in_seg1} && !fetch_addr[15];
    wdog_off_a: assert property (boot_loader_mode |-> watchdog_disable)
        else $error("watchdog active in boot mode");
    cfg_forced_a: assert property (cfg_load |-> system_configuration == 16'h0E00 && serial_control == 16'h8011)
        else $error("forced values wrong");
    tx_driven_a: assert property (boot_loader_mode |-> !transmit_direction_bit)
        else $error("transmit pin not driven");
    code_redirect_a: assert property (boot_loader_mode && fetch_is_code && in_flash |-> fetch_to_boot_rom)
        else $error("code fetch not redirected");
    data_user_a: assert property (!fetch_is_code || !boot_loader_mode |-> !fetch_to_boot_rom)
        else $error("data or normal fetch redirected");
    window_follow_a: assert property (fetch_is_code && !in_flash |-> !fetch_to_boot_rom)
        else $error("redirect outside flash window");
    ea_ignored_a: assert property (boot_loader_mode && $past(boot_loader_mode) && $changed(external_access_pin)
        |-> $stable(flash_use_external))
        else $error("external access pin obeyed");
    load_window_a: assert property (ram_wr_valid |-> ram_wr_addr >= 24'h00FA40 && ram_wr_addr <= 24'h00FA5F)
        else $error("store address outside load area");
    stall_hold_a: assert property (ram_wr_valid && !ram_wr_ready |=> ram_wr_valid && $stable(ram_wr_data))
        else $error("byte lost during stall");
    jump_once_a: assert property (jump_valid |-> jump_addr == 24'h00FA40 ##1 !jump_valid)
        else $error("jump wrong");
    sw_exit_a: assert property (sw_reset |=> !boot_loader_mode)
        else $error("boot mode kept after software reset");
    cover property (jump_valid);
    cover property (ram_wr_valid && !ram_wr_ready);
    cover property (boot_loader_mode && sw_reset);
endmodule // sbl_loader_props

bind sbl_loader sbl_loader_props i_props (.*);

/* File: tb.sv */
// Testbench for the serial boot loader entry logic
`timescale 1ns/1ps
module tb;
    localparam [7:0] ID = 8'h3C; // Arbitrary id value
    reg core_clk = 0, rst_n = 0, boot_select_pin = 0, external_access_pin = 0, bus_mode_strap = 0;
    reg sw_reset = 0, fetch_is_code = 0, flash_in_seg1 = 0, ram_wr_ready = 0, start = 0;
    reg psel = 0, penable = 0, pwrite = 0;
    reg [23:0] fetch_addr = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, r;
    reg [255:0] payload = 0;
    reg [15:0] zero_len = 0, bit_clks = 0, exp_rl;
    wire serial_receive_pin, serial_transmit_pin, transmit_direction_bit, ram_wr_valid, jump_valid;
    wire boot_loader_mode, watchdog_disable, cfg_load, fetch_to_boot_rom, flash_use_external;
    wire pready, pslverr, id_ok;
    wire [23:0] ram_wr_addr, jump_addr;
    wire [7:0] ram_wr_data, id_byte;
    wire [15:0] system_configuration, context_base_pointer, stack_pointer, stack_underflow_limit;
    wire [15:0] stack_overflow_limit, serial_control, baud_reload_value;
    wire [31:0] prdata;
    integer n_mismatch = 0, num_checks = 0, nb = 0, jumps = 0, stall = 0, i, n;

    sbl_loader #(.ID_BYTE(ID)) i_dut (.*);
    sbl_host_model i_host (.core_clk(core_clk), .start(start), .zero_len(zero_len), .bit_clks(bit_clks),
        .payload(payload), .serial_transmit_pin(serial_transmit_pin),
        .serial_receive_pin(serial_receive_pin), .id_byte(id_byte), .id_ok(id_ok));

    always #5 core_clk = ~core_clk;

    task chk(input [31:0] got, input [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
        r = prdata;
        {psel, penable} <= 2'b00;
    endtask

    function [15:0] f_reload(input [15:0] c);
        f_reload = (c - 16'h0024) / 16'h0048;
    endfunction

    // Byte sink with random stalls; one long stall fills the buffer
    always @(posedge core_clk) begin
        if (ram_wr_valid === 1'b1 && ram_wr_ready) begin
            chk(ram_wr_addr, 24'h00FA40 + nb);
            chk(ram_wr_data, payload[nb*8 +: 8]);
            nb = nb + 1;
            // Serial host cannot be stalled: short gaps, one long stall that fills the buffer
            stall = (nb == 6) ? 1300 : $urandom % 400;
        end
        if (jump_valid === 1'b1) jumps = jumps + 1;
        ram_wr_ready <= (stall == 0);
        if (stall > 0) stall = stall - 1;
    end

    initial begin
        void'($urandom(63870));
        bus_mode_strap <= $urandom;
        external_access_pin <= $urandom;
        for (i = 0; i < 8; i = i + 1) payload[i*32 +: 32] = $urandom;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk(boot_loader_mode, 1);
        chk(watchdog_disable, 1);
        chk({transmit_direction_bit, serial_transmit_pin}, 2'b01);
        chk({system_configuration, context_base_pointer}, 32'h0E00FA00);
        chk({stack_pointer, stack_underflow_limit}, 32'hFA40FA40);
        chk({stack_overflow_limit, serial_control}, 32'hFA0C8011);
        $display("test entry done");
        for (i = 0; i < 32; i = i + 1) begin
            @(posedge core_clk);
            {fetch_is_code, flash_in_seg1, external_access_pin} <= {i[0], i[1], i[3]};
            fetch_addr <= {7'h00, i[2], i[4], 15'($urandom)};
            @(negedge core_clk);
            chk(fetch_to_boot_rom, i[0] && i[1] == i[2] && !i[4]);
            chk(flash_use_external, 0);
        end
        $display("test fetch done");
        zero_len = 16'd150 + $urandom % 20;
        exp_rl = f_reload(zero_len);
        bit_clks = 16'h0020 * (exp_rl + 16'h0001);
        start <= 1'b1;
        n = 0;
        while (jumps == 0 && n < 40000) begin
            @(posedge core_clk);
            n = n + 1;
        end
        if (n >= 40000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
        repeat (2) @(posedge core_clk);
        #1;
        chk(baud_reload_value, exp_rl);
        chk({id_ok, id_byte}, {1'b1, ID});
        chk(nb, 32);
        chk(jumps, 1);
        chk(jump_addr, 24'h00FA40);
        $display("test boot done");
        apb(0, 12'h008, 0);
        chk(r, {16'h0000, exp_rl});
        apb(0, 12'h01C, 0);
        chk(r[7:0], ID);
        apb(1, 12'h004, 32'h1);
        apb(0, 12'h004, 0);
        chk(r[0], 1);
        apb(0, 12'h00C, 0);
        chk(r, 32'hFA000E00);
        apb(0, 12'h040, 0);
        chk(r, 0);
        apb(0, 12'h000, 0);
        chk({r[7:2], r[0]}, 7'h41);
        chk({pslverr, r[16]}, {1'b0, bus_mode_strap});
        $display("test registers done");
        @(posedge core_clk);
        sw_reset <= 1'b1;
        @(posedge core_clk);
        sw_reset <= 1'b0;
        @(negedge core_clk);
        chk(boot_loader_mode, 0);
        boot_select_pin <= 1'b1;
        rst_n <= 1'b0;
        {fetch_is_code, flash_in_seg1, fetch_addr} <= {2'b10, 24'h000100};
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk({boot_loader_mode, fetch_to_boot_rom}, 0);
        chk(flash_use_external, !external_access_pin);
        $display("test exit done");
        stop_test;
    end
endmodule // tb
